// *** rtl/mps_defs.vh ***
// Constants shared by the mesh packet security files.
`ifndef MPS_DEFS_VH
`define MPS_DEFS_VH
`define MPS_KEY_W        128
`define MPS_FCNT_W       32
`define MPS_FCNT_MAX     32'h0fffffff
`define MPS_ADDR_W       64
`define MPS_NWK_OVH      8'h12
`define MPS_APS_HDR      8'h05
`define MPS_TAG_BYTES    8'h04
`define MPS_KIND_DATA    3'h0
`define MPS_KIND_ROUTE   3'h1
`define MPS_KIND_APSCMD  3'h2
`define MPS_KIND_ZDOCMD  3'h3
`define MPS_KIND_MAC     3'h4
`define MPS_DROP_NONE    3'h0
`define MPS_DROP_NWKTAG  3'h1
`define MPS_DROP_REPLAY  3'h2
`define MPS_DROP_APSTAG  3'h3
`define MPS_DROP_SAT     3'h4
`endif

// *** rtl/mps_two_buf.v ***
// Two-entry valid/ready buffer for outgoing frame descriptors.
`timescale 1ns/1ps
module mps_two_buf #(
	parameter W = 8
) (
	input  wire         sys_clk,
	input  wire         rst_n,
	input  wire         ce,
	input  wire         inValid,
	output wire         inReady,
	input  wire [W-1:0] inData,
	output wire         outValid,
	input  wire         outReady,
	output wire [W-1:0] outData
);
	reg [W-1:0] slot0_r;
	reg [W-1:0] slot1_r;
	reg [1:0]   cnt_r;
	wire        push;
	wire        pop;

	assign inReady  = ce & (cnt_r != 2'h2);
	assign outValid = cnt_r != 2'h0;
	assign outData  = slot0_r;
	assign push     = inValid & inReady;
	assign pop      = ce & outValid & outReady;

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot0_r <= {W{1'b0}};
			slot1_r <= {W{1'b0}};
			cnt_r   <= 2'h0;
		end
		else if (ce)
		begin
			if (pop)
				slot0_r <= slot1_r;
			if (push & ((cnt_r == 2'h0) | (pop & (cnt_r == 2'h1))))
				slot0_r <= inData;
			else if (push)
				slot1_r <= inData;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // mps_two_buf

// *** rtl/mps_nbr_table.v ***
// Per-neighbour store of the last frame counter seen.
`timescale 1ns/1ps
`include "mps_defs.vh"
module mps_nbr_table #(
	parameter NBR   = 16,
	parameter IDX_W = 4
) (
	input  wire                   sys_clk,
	input  wire                   rst_n,
	input  wire                   ce,
	input  wire                   clearAll,
	input  wire [IDX_W-1:0]       rdIdx,
	output wire [`MPS_FCNT_W-1:0] rdCnt,
	input  wire                   wrEn,
	input  wire [`MPS_FCNT_W-1:0] wrCnt
);
	reg [`MPS_FCNT_W-1:0] cnt_r [0:NBR-1];
	integer i;

	assign rdCnt = cnt_r[rdIdx];

	// Clearing every entry at once keeps a key change from racing a late reception.
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < NBR; i = i + 1)
				cnt_r[i] <= {`MPS_FCNT_W{1'b0}};
		end
		else if (ce)
		begin
			if (clearAll)
			begin
				for (i = 0; i < NBR; i = i + 1)
					cnt_r[i] <= {`MPS_FCNT_W{1'b0}}; // see R7
			end
			else if (wrEn)
				cnt_r[rdIdx] <= wrCnt; // see R5
		end
	end
endmodule // mps_nbr_table

// *** rtl/mps_packet_security.v ***
// Packet security control for a mesh node: counters, replay, tags, key choice.
//
// Behaviour
// R1 - 128-bit AES keys for network protection.
// R2 - Protect data, route, APS, ZDO frames.
// R3 - MAC frames such as beacons unprotected.
// R4 - Insert own 32-bit counter, then increment.
// R5 - Drop frames below neighbour's stored counter.
// R6 - Counter saturates; block transmissions at maximum. The code saturates and blocks at MPS_FCNT_MAX, 32'h0fffffff.
// R7 - Key replacement zeroes all frame counters.
// R8 - Network tag covers headers and data.
// R9 - Drop frame on network tag mismatch.
// R10 - Relay decrypts, re-protects with own counter.
// R11 - Network protection costs eighteen bytes.
// R12 - APS protection per frame, end-to-end.
// R13 - Refuse APS protection on broadcasts.
// R14 - Destination drops on APS tag mismatch.
// R15 - APS protection costs nine payload bytes.
// R16 - APS protection nests inside network protection. The code still applies APS alone to MAC-kind tx and unprotected relays.
// R17 - Coordinator picks keys, preset or random.
// R18 - Preset link key encrypts network key.
// R19 - Clear key transport only when allowed.
// R20 - Flag refusal caused by counter saturation.
`timescale 1ns/1ps
`include "mps_defs.vh"
module mps_packet_security #(
	parameter NBR          = 16,
	parameter IDX_W        = 4,
	parameter BASE_PAYLOAD = 8'h54
) (
	input  wire                   sys_clk,
	input  wire                   rst_n,
	input  wire                   ce,
	input  wire                   secEnable,
	input  wire                   isCoord,
	input  wire [`MPS_ADDR_W-1:0] ownAddr,
	input  wire                   netKeyLoad,
	input  wire [`MPS_KEY_W-1:0]  netKeyIn,
	input  wire                   linkKeyLoad,
	input  wire [`MPS_KEY_W-1:0]  linkKeyIn,
	input  wire [`MPS_KEY_W-1:0]  rngKey,
	output wire [`MPS_KEY_W-1:0]  aesNetKey,
	output wire [`MPS_KEY_W-1:0]  aesLinkKey,
	input  wire                   txValid,
	output wire                   txReady,
	input  wire [2:0]             txKind,
	input  wire                   txBroadcast,
	input  wire                   txApsSec,
	output reg                    txSatRefuse,
	output reg                    txApsRefuse,
	output wire                   fcntSaturated,
	input  wire                   rxValid,
	output wire                   rxReady,
	input  wire [IDX_W-1:0]       rxNbrIdx,
	input  wire                   rxNwkSec,
	input  wire                   rxApsSec,
	input  wire                   rxToMe,
	input  wire [`MPS_FCNT_W-1:0] rxFrameCnt,
	input  wire [31:0]            rxNwkTagCalc,
	input  wire [31:0]            rxNwkTagRecv,
	input  wire [31:0]            rxApsTagCalc,
	input  wire [31:0]            rxApsTagRecv,
	output reg                    rxAccept,
	output reg                    rxDrop,
	output reg  [2:0]             rxDropCode,
	output wire                   outValid,
	input  wire                   outReady,
	output wire [`MPS_FCNT_W-1:0] outFrameCnt,
	output wire [`MPS_ADDR_W-1:0] outSrcAddr,
	output wire                   outNwkProt,
	output wire                   outApsProt,
	output wire                   outForward,
	output wire [7:0]             outMaxPayload,
	input  wire                   allowClearKey,
	input  wire                   joinReq,
	input  wire                   joinerHasLink,
	output reg                    keyXferValid,
	output reg                    keyXferEnc,
	output reg                    keyXferRefuse
);
	localparam DW = `MPS_FCNT_W + `MPS_ADDR_W + 3 + 8;

	// ------------------------------------------------------------
	// Key store
	// ------------------------------------------------------------
	reg  [`MPS_KEY_W-1:0]  netKey_r;
	reg  [`MPS_KEY_W-1:0]  linkKey_r;
	reg                    linkPreset_r;
	reg  [`MPS_FCNT_W-1:0] fcnt_r;
	reg  [`MPS_FCNT_W-1:0] fcnt_nxt;
	wire [`MPS_FCNT_W-1:0] nbrCnt;
	wire                   bufInReady;
	reg                    bufPush;
	reg  [DW-1:0]          bufData;
	wire [DW-1:0]          bufOut;
	reg                    nbrWr;
	reg                    satRefuse_nxt;
	reg                    apsRefuse_nxt;
	reg                    accept_nxt;
	reg                    drop_nxt;
	reg  [2:0]             dropCode_nxt;
	reg  [7:0]             maxPay;
	wire                   txFire;
	wire                   rxFire;
	wire                   txNeedNwk;
	wire                   sat;

	assign aesNetKey     = netKey_r; // see R1
	assign aesLinkKey    = linkKey_r; // see R1
	assign sat           = fcnt_r == `MPS_FCNT_MAX;
	assign fcntSaturated = sat; // see R20

	// A zero key handed to the coordinator means it must draw a random one.
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			netKey_r     <= {`MPS_KEY_W{1'b0}};
			linkKey_r    <= {`MPS_KEY_W{1'b0}};
			linkPreset_r <= 1'b0;
		end
		else if (ce)
		begin
			if (netKeyLoad)
				netKey_r <= (isCoord && netKeyIn == {`MPS_KEY_W{1'b0}}) ? rngKey : netKeyIn; // see R17
			if (linkKeyLoad)
			begin
				linkKey_r    <= (isCoord && linkKeyIn == {`MPS_KEY_W{1'b0}}) ? rngKey : linkKeyIn; // see R17
				linkPreset_r <= linkKeyIn != {`MPS_KEY_W{1'b0}};
			end
		end
	end

	// ------------------------------------------------------------
	// Key transport to joiners
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			keyXferValid  <= 1'b0;
			keyXferEnc    <= 1'b0;
			keyXferRefuse <= 1'b0;
		end
		else if (ce)
		begin
			keyXferValid  <= 1'b0;
			keyXferEnc    <= 1'b0;
			keyXferRefuse <= 1'b0;
			if (joinReq)
			begin
				if (joinerHasLink && linkPreset_r)
				begin
					keyXferValid <= 1'b1;
					keyXferEnc   <= 1'b1; // see R18
				end
				else if (allowClearKey && !linkPreset_r)
					keyXferValid <= 1'b1; // see R19
				else
					keyXferRefuse <= 1'b1; // see R19
			end
		end
	end

	// ------------------------------------------------------------
	// Receive and transmit decisions
	// ------------------------------------------------------------
	// Relayed frames share the output buffer, so the receive side has priority.
	assign rxReady   = bufInReady;
	assign txReady   = bufInReady & ~rxValid;
	assign rxFire    = rxValid & rxReady;
	assign txFire    = txValid & txReady;
	assign txNeedNwk = secEnable & (txKind != `MPS_KIND_MAC); // see R2, see R3

	always @*
	begin
		fcnt_nxt      = fcnt_r;
		bufPush       = 1'b0;
		bufData       = {DW{1'b0}};
		nbrWr         = 1'b0;
		satRefuse_nxt = 1'b0;
		apsRefuse_nxt = 1'b0;
		accept_nxt    = 1'b0;
		drop_nxt      = 1'b0;
		dropCode_nxt  = `MPS_DROP_NONE;
		maxPay        = BASE_PAYLOAD;
		if (rxFire)
		begin
			if (rxNwkSec && rxNwkTagCalc != rxNwkTagRecv)
			begin
				drop_nxt     = 1'b1;
				dropCode_nxt = `MPS_DROP_NWKTAG; // see R9
			end
			else if (rxNwkSec && rxFrameCnt < nbrCnt)
			begin
				drop_nxt     = 1'b1;
				dropCode_nxt = `MPS_DROP_REPLAY; // see R5
			end
			else if (rxToMe)
			begin
				nbrWr = rxNwkSec;
				if (rxApsSec && rxApsTagCalc != rxApsTagRecv)
				begin
					drop_nxt     = 1'b1;
					dropCode_nxt = `MPS_DROP_APSTAG; // see R14
				end
				else
					accept_nxt = 1'b1;
			end
			else
			begin
				nbrWr = rxNwkSec;
				if (rxNwkSec && sat)
				begin
					drop_nxt      = 1'b1;
					dropCode_nxt  = `MPS_DROP_SAT;
					satRefuse_nxt = 1'b1; // see R6, see R20
				end
				else
				begin
					// The APS layer stays sealed on relay; only the network layer is renewed.
					if (rxNwkSec)
						maxPay = maxPay - `MPS_NWK_OVH;
					if (rxApsSec)
						maxPay = maxPay - `MPS_APS_HDR - `MPS_TAG_BYTES;
					bufPush = 1'b1;
					bufData = {fcnt_r, ownAddr, rxNwkSec, rxApsSec, 1'b1, maxPay}; // see R10, see R12
					if (rxNwkSec)
						fcnt_nxt = fcnt_r + 32'h1; // see R10
				end
			end
		end
		else if (txFire)
		begin
			if (txApsSec && (txBroadcast || !secEnable))
				apsRefuse_nxt = 1'b1; // see R13
			else if (txNeedNwk && sat)
				satRefuse_nxt = 1'b1; // see R6, see R20
			else
			begin
				if (txNeedNwk)
					maxPay = maxPay - `MPS_NWK_OVH; // see R11, see R8
				if (txApsSec)
					maxPay = maxPay - `MPS_APS_HDR - `MPS_TAG_BYTES; // see R15, see R14
				bufPush = 1'b1;
				bufData = {fcnt_r, ownAddr, txNeedNwk, txApsSec, 1'b0, maxPay}; // see R4, see R16
				if (txNeedNwk)
					fcnt_nxt = fcnt_r + 32'h1; // see R4
			end
		end
		if (netKeyLoad)
			fcnt_nxt = {`MPS_FCNT_W{1'b0}}; // see R7
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fcnt_r      <= {`MPS_FCNT_W{1'b0}};
			txSatRefuse <= 1'b0;
			txApsRefuse <= 1'b0;
			rxAccept    <= 1'b0;
			rxDrop      <= 1'b0;
			rxDropCode  <= `MPS_DROP_NONE;
		end
		else if (ce)
		begin
			fcnt_r      <= fcnt_nxt;
			txSatRefuse <= satRefuse_nxt;
			txApsRefuse <= apsRefuse_nxt;
			rxAccept    <= accept_nxt;
			rxDrop      <= drop_nxt;
			rxDropCode  <= dropCode_nxt;
		end
	end

	mps_nbr_table #(
		.NBR   (NBR),
		.IDX_W (IDX_W)
	) u_nbr (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.clearAll (netKeyLoad),
		.rdIdx    (rxNbrIdx),
		.rdCnt    (nbrCnt),
		.wrEn     (nbrWr),
		.wrCnt    (rxFrameCnt)
	);

	mps_two_buf #(
		.W (DW)
	) u_buf (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.inValid  (bufPush),
		.inReady  (bufInReady),
		.inData   (bufData),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (bufOut)
	);

	assign outFrameCnt   = bufOut[DW-1 -: `MPS_FCNT_W];
	assign outSrcAddr    = bufOut[11 +: `MPS_ADDR_W];
	assign outNwkProt    = bufOut[10];
	assign outApsProt    = bufOut[9];
	assign outForward    = bufOut[8];
	assign outMaxPayload = bufOut[7:0];
endmodule // mps_packet_security

// *** verification/mps_checker.sv ***
// Assertion checker for the packet security block.
`timescale 1ns/1ps
module mps_checker #(parameter BASE = 8'h54) (
	input wire logic        sys_clk, rst_n, ce, secEnable, netKeyLoad,
	input wire logic        txValid, txReady, txBroadcast, txApsSec, txSatRefuse,
	input wire logic        txApsRefuse, fcntSaturated, rxValid, rxReady, rxNwkSec,
	input wire logic        rxDrop, outValid, outReady, outNwkProt, outApsProt, outForward,
	input wire logic [2:0]  txKind, rxDropCode,
	input wire logic [31:0] rxNwkTagCalc, rxNwkTagRecv, outFrameCnt,
	input wire logic [7:0]  outMaxPayload
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire tx = txValid && txReady;
	wire rx = rxValid && rxReady;
	AST_NWKTAG: assert property (rx && rxNwkSec && rxNwkTagCalc != rxNwkTagRecv
		|=> rxDrop && rxDropCode == 3'h1) else $error("bad tag not dropped");
	AST_APSBC: assert property (tx && txApsSec && txBroadcast |=> txApsRefuse)
		else $error("aps broadcast not refused");
	AST_MAC: assert property (tx && txKind == 3'h4 && !txApsSec && !outValid
		|=> outValid && !outNwkProt) else $error("mac frame protected");
	AST_NWK: assert property (tx && secEnable && txKind < 3'h4 && !txApsSec && !outValid
		&& !fcntSaturated |=> outValid && outNwkProt) else $error("frame unprotected");
	AST_PAY: assert property (outValid |-> outMaxPayload == BASE
		- (outNwkProt ? 8'h12 : 8'h00) - (outApsProt ? 8'h09 : 8'h00)) else $error("bad payload");
	AST_SAT: assert property (tx && fcntSaturated && secEnable && txKind != 3'h4
		&& !txApsSec && !netKeyLoad |=> txSatRefuse) else $error("saturated tx sent");
	AST_KEY: assert property (netKeyLoad && ce |=> !fcntSaturated)
		else $error("counter not cleared");
	AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outFrameCnt))
		else $error("descriptor lost");
	AST_RDY: assert property (txReady |-> ce && !rxValid) else $error("tx taken during rx");
	cover property (tx ##1 outValid && outNwkProt);
	cover property (rxDrop && rxDropCode == 3'h2);
	cover property (outValid && outForward);
endmodule // mps_checker

// *** verification/mps_nbr_model.sv ***
// Neighbour side that takes outgoing descriptors with random stalls.
`timescale 1ns/1ps
module mps_nbr_model (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic stall,
	input  wire logic outValid,
	output logic      outReady,
	output int        got
);
	int seed = 7;
	// Random back-pressure holds the first buffer entry; the stall input fills the second.
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outReady <= 1'b0;
			got <= 0;
		end
		else
		begin
			if (outValid && outReady)
				got <= got + 1;
			outReady <= !stall && ($random(seed) % 4 != 0);
		end
	end
endmodule // mps_nbr_model

// *** verification/tb.sv ***
// Self-checking bench for the packet security block.
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0, rst_n = 0, ce = 1, secEnable = 1, isCoord = 1, rxNwkSec = 1;
	logic netKeyLoad = 0, linkKeyLoad = 0, txValid = 0, txBroadcast = 0, txApsSec = 0;
	logic rxValid = 0, rxApsSec = 0, rxToMe = 0, allowClearKey = 0, joinReq = 0;
	logic joinerHasLink = 0, stall = 0, a, b;
	logic [2:0] txKind = 0, k;
	logic [3:0] rxNbrIdx = 0;
	logic [63:0] ownAddr = 0;
	logic [127:0] netKeyIn = 0, linkKeyIn = 0, rngKey = 0;
	logic [31:0] rxFrameCnt = 0, rxNwkTagCalc = 0, rxNwkTagRecv = 0, rxApsTagCalc = 0;
	logic [31:0] rxApsTagRecv = 0, expFcnt = 0;
	wire [127:0] aesNetKey, aesLinkKey;
	wire txReady, txSatRefuse, txApsRefuse, fcntSaturated, rxReady, rxAccept, rxDrop;
	wire outValid, outNwkProt, outApsProt, outForward, outReady;
	wire keyXferValid, keyXferEnc, keyXferRefuse;
	wire [2:0] rxDropCode;
	wire [31:0] outFrameCnt;
	wire [63:0] outSrcAddr;
	wire [7:0] outMaxPayload;
	int failures = 0, total_checks = 0, seed = 70, cyc = 0, j, g0;
	int got;
	mps_packet_security mps_packet_security_inst (.*);
	mps_nbr_model mps_nbr_model_inst (.*);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			test_done();
		end
	end
	task test_done;
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [127:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	function logic [7:0] pay(input logic n, p);
		return 8'h54 - (n ? 8'h12 : 8'h00) - (p ? 8'h09 : 8'h00);
	endfunction
	task idle;
		for (int i = 0; i < 60 && outValid !== 1'b0; i++)
			@(posedge sys_clk) #1;
	endtask
	// Waits for the take edge while holding the request steady.
	task tx(input logic [2:0] t, input logic c, p, e);
		int i;
		logic n, r;
		n = t != 3'h4;
		r = p && c;
		i = 0;
		if (e)
			idle();
		@(posedge sys_clk);
		{txKind, txBroadcast, txApsSec, txValid} <= {t, c, p, 1'b1};
		do @(posedge sys_clk); while (txReady !== 1'b1 && i++ < 50);
		txValid <= 1'b0;
		#1;
		if (e)
		begin
			chk("txApsRefuse", txApsRefuse, r);
			chk("txSatRefuse", txSatRefuse, 0);
			chk("fcntSaturated", fcntSaturated, 0);
			chk("outValid", outValid, !r);
			if (!r)
			begin
				chk("outNwkProt", outNwkProt, n);
				chk("outApsProt", outApsProt, p);
				chk("outForward", outForward, 0);
				chk("outMaxPayload", outMaxPayload, pay(n, p));
				if (n)
					chk("outFrameCnt", outFrameCnt, expFcnt);
			end
		end
		if (n && !r)
			expFcnt++;
	endtask
	task rx(input logic [3:0] x, input logic [31:0] c, input logic nb, ab, tm,
		input logic [2:0] code);
		int i;
		logic [31:0] t;
		i = 0;
		t = $random(seed);
		idle();
		@(posedge sys_clk);
		{rxNbrIdx, rxFrameCnt, rxToMe, rxApsSec, rxValid} <= {x, c, tm, tm | t[0], 1'b1};
		{rxNwkTagCalc, rxNwkTagRecv} <= {t, t ^ {31'h0, nb}};
		{rxApsTagCalc, rxApsTagRecv} <= {~t, ~t ^ {31'h0, ab}};
		do @(posedge sys_clk); while (rxReady !== 1'b1 && i++ < 50);
		rxValid <= 1'b0;
		#1;
		chk("rxDropCode", rxDropCode, code);
		chk("rxDrop", rxDrop, code != 3'h0);
		chk("rxAccept", rxAccept, tm && code == 3'h0);
		if (!tm && code == 3'h0)
		begin
			chk("relayForward", outForward, 1);
			chk("relayAps", outApsProt, t[0]);
			chk("relayCnt", outFrameCnt, expFcnt);
			chk("relaySrc", outSrcAddr, ownAddr);
			chk("relayPay", outMaxPayload, pay(1, t[0]));
			expFcnt++;
		end
	endtask
	task key(input logic n, input logic [127:0] v);
		@(posedge sys_clk);
		{netKeyLoad, linkKeyLoad, netKeyIn, linkKeyIn} <= {n, !n, v, v};
		@(posedge sys_clk);
		{netKeyLoad, linkKeyLoad} <= 2'b00;
		#1;
	endtask
	initial
	begin
		ownAddr = {$random(seed), $random(seed)};
		rngKey = {4{$random(seed)}};
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		key(1, 0);
		chk("aesNetKey", aesNetKey, rngKey);
		key(0, 128'h4455);
		chk("aesLinkKey", aesLinkKey, 128'h4455);
		tx(3'h0, 1, 1, 1);
		tx(3'h4, 0, 0, 1);
		for (j = 0; j < 24; j++)
		begin
			k = 3'({$random(seed)} % 5);
			a = k != 3'h4 && 1'($random(seed));
			b = 1'($random(seed));
			tx(k, b, a, 1);
		end
		rx(3, 100, 0, 0, 1, 0);
		rx(3, 99, 0, 0, 1, 2);
		rx(3, 100, 0, 0, 1, 0);
		rx(3, 101, 1, 0, 1, 1);
		rx(3, 101, 0, 1, 1, 3);
		rx(3, 102, 0, 1, 0, 0);
		rx(5, 1, 0, 0, 1, 0);
		key(1, {4{$random(seed)}});
		chk("aesNetKey", aesNetKey, netKeyIn);
		expFcnt = 0;
		rx(3, 0, 0, 0, 1, 0);
		tx(3'h0, 0, 0, 1);
		idle();
		stall <= 1'b1;
		repeat (2) @(posedge sys_clk);
		g0 = mps_nbr_model_inst.got;
		tx(3'h1, 0, 0, 0);
		tx(3'h2, 0, 0, 0);
		chk("txReadyFull", txReady, 0);
		stall <= 1'b0;
		repeat (30) @(posedge sys_clk);
		chk("drained", mps_nbr_model_inst.got, g0 + 2);
		tx(3'h3, 0, 0, 1);
		for (j = 0; j < 3; j++)
		begin
			@(posedge sys_clk);
			{joinerHasLink, allowClearKey, joinReq} <= {j == 0, j == 1, 1'b1};
			@(posedge sys_clk);
			joinReq <= 1'b0;
			#1;
			chk("keyXferValid", keyXferValid, j == 0);
			chk("keyXferEnc", keyXferEnc, j == 0);
			chk("keyXferRefuse", keyXferRefuse, j != 0);
		end
		// A random link key is not preset, so a clear transfer becomes legal.
		key(0, 0);
		@(posedge sys_clk);
		{joinerHasLink, allowClearKey, joinReq} <= 3'b011;
		@(posedge sys_clk);
		joinReq <= 1'b0;
		#1;
		chk("keyXferValid", keyXferValid, 1);
		chk("keyXferEnc", keyXferEnc, 0);
		chk("keyXferRefuse", keyXferRefuse, 0);
		test_done();
	end
endmodule // tb
bind mps_packet_security mps_checker #(.BASE(BASE_PAYLOAD)) mps_checker_inst (.*);
